// file: common/bstp_regs.svh
// Constants for the boundary-scan test port
`ifndef BSTP_REGS_SVH
`define BSTP_REGS_SVH

`define BSTP_IR_LEN 3
`define BSTP_IR_CAPTURE 3'h1
`define BSTP_OP_EXTEST 3'h0
`define BSTP_OP_SAMPLE 3'h5
`define BSTP_OP_BYPASS 3'h7
`define BSTP_BSR_LEN_SMALL 522
`define BSTP_BSR_LEN_MID 621
`define BSTP_BSR_LEN_LARGE 666
`define BSTP_CELLS_PER_PIN 3
`define BSTP_CELL_IN 0
`define BSTP_CELL_OUT 1
`define BSTP_CELL_OE 2

`endif

// file: common/bstp_pkg.sv
// Types for the boundary-scan test port
package bstp_pkg;

  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } bstp_tap_state_e;

endpackage : bstp_pkg

// file: logic/bstp_tap_fsm.sv
// Sixteen-state test access controller stepped by TMS on rising TCK
`timescale 1ns/1ps

module bstp_tap_fsm (
  input wire logic tck_i,
  input wire logic rst_i,
  input wire logic tms_i,
  output bstp_pkg::bstp_tap_state_e state_o
);

  bstp_pkg::bstp_tap_state_e state;
  bstp_pkg::bstp_tap_state_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      bstp_pkg::TAP_RESET: next_state = tms_i ? bstp_pkg::TAP_RESET : bstp_pkg::TAP_IDLE;
      bstp_pkg::TAP_IDLE: next_state = tms_i ? bstp_pkg::TAP_SEL_DR : bstp_pkg::TAP_IDLE;
      bstp_pkg::TAP_SEL_DR: next_state = tms_i ? bstp_pkg::TAP_SEL_IR : bstp_pkg::TAP_CAP_DR;
      bstp_pkg::TAP_CAP_DR: next_state = tms_i ? bstp_pkg::TAP_EXIT1_DR : bstp_pkg::TAP_SHIFT_DR;
      bstp_pkg::TAP_SHIFT_DR: next_state = tms_i ? bstp_pkg::TAP_EXIT1_DR : bstp_pkg::TAP_SHIFT_DR;
      bstp_pkg::TAP_EXIT1_DR: next_state = tms_i ? bstp_pkg::TAP_UPD_DR : bstp_pkg::TAP_PAUSE_DR;
      bstp_pkg::TAP_PAUSE_DR: next_state = tms_i ? bstp_pkg::TAP_EXIT2_DR : bstp_pkg::TAP_PAUSE_DR;
      bstp_pkg::TAP_EXIT2_DR: next_state = tms_i ? bstp_pkg::TAP_UPD_DR : bstp_pkg::TAP_SHIFT_DR;
      bstp_pkg::TAP_UPD_DR: next_state = tms_i ? bstp_pkg::TAP_SEL_DR : bstp_pkg::TAP_IDLE;
      bstp_pkg::TAP_SEL_IR: next_state = tms_i ? bstp_pkg::TAP_RESET : bstp_pkg::TAP_CAP_IR;
      bstp_pkg::TAP_CAP_IR: next_state = tms_i ? bstp_pkg::TAP_EXIT1_IR : bstp_pkg::TAP_SHIFT_IR;
      bstp_pkg::TAP_SHIFT_IR: next_state = tms_i ? bstp_pkg::TAP_EXIT1_IR : bstp_pkg::TAP_SHIFT_IR;
      bstp_pkg::TAP_EXIT1_IR: next_state = tms_i ? bstp_pkg::TAP_UPD_IR : bstp_pkg::TAP_PAUSE_IR;
      bstp_pkg::TAP_PAUSE_IR: next_state = tms_i ? bstp_pkg::TAP_EXIT2_IR : bstp_pkg::TAP_PAUSE_IR;
      bstp_pkg::TAP_EXIT2_IR: next_state = tms_i ? bstp_pkg::TAP_UPD_IR : bstp_pkg::TAP_SHIFT_IR;
      bstp_pkg::TAP_UPD_IR: next_state = tms_i ? bstp_pkg::TAP_SEL_DR : bstp_pkg::TAP_IDLE;
      default: next_state = bstp_pkg::TAP_RESET;
    endcase
  end

  // Forced reset also covers the configuration hold-off
  always_ff @(posedge tck_i) begin
    if (rst_i) begin
      state <= bstp_pkg::TAP_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign state_o = state;

endmodule : bstp_tap_fsm

// file: logic/bstp_top.sv
// Boundary-scan test port: TAP, instruction, bypass and boundary registers, pad muxing
//
// Behaviour
// - Sample/preload captures pin state without disturbing pins; shifted pattern kept for later.
// - External test drives boundary output cells onto pins and captures pin inputs.
// - Bypass puts one flip-flop between TDI and TDO, one TCK delay.
// - Instruction register is three bits; tester shifts three bits per device.
// - Boundary length is a variant parameter: 522, 621 or 666 cells.
// - Test logic held in reset during configuration unless user-mode disable set.
// - Undriven TMS or TDI reads as logic high.
`timescale 1ns/1ps
`include "bstp_regs.svh"

module bstp_top #(
  parameter int BSR_LEN = `BSTP_BSR_LEN_SMALL,
  parameter int NUM_PINS = BSR_LEN / `BSTP_CELLS_PER_PIN
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tms_driven_i,
  input wire logic tdi_i,
  input wire logic tdi_driven_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  input wire logic cfg_busy_i,
  input wire logic user_test_disable_i,
  input wire logic [NUM_PINS-1:0] core_out_i,
  input wire logic [NUM_PINS-1:0] core_oe_i,
  input wire logic [NUM_PINS-1:0] pad_in_i,
  output logic [NUM_PINS-1:0] pad_out_o,
  output logic [NUM_PINS-1:0] pad_oe_n_o
);

  // Cell index of a given kind for a given pin
  function automatic int cell_idx(input int pin, input int kind);
    return pin * `BSTP_CELLS_PER_PIN + kind;
  endfunction : cell_idx

  // TCK domain
  logic rst_s1, rst_s2, cfg_s1, cfg_s2, dis_s1, dis_s2;
  logic [NUM_PINS-1:0] pin_s1, pin_s2, cout_s1, cout_s2, coe_s1, coe_s2;
  logic tap_rst;
  logic tms_eff, tdi_eff;
  bstp_pkg::bstp_tap_state_e tap_state;

  logic [`BSTP_IR_LEN-1:0] ir_sh, ir, next_ir_sh, next_ir;
  logic byp, next_byp;
  logic [BSR_LEN-1:0] bsr_sh, bsr_upd, next_bsr_sh, next_bsr_upd;
  logic upd_tgl, next_upd_tgl;
  logic extest, bsr_sel, ext_tck, next_ext_tck;
  logic next_tdo, next_tdo_oe_n;

  // Every asynchronous level into the TCK domain gets two flops
  always_ff @(posedge tck_i) begin
    rst_s1 <= sys_rst_i;
    rst_s2 <= rst_s1;
    cfg_s1 <= cfg_busy_i;
    cfg_s2 <= cfg_s1;
    dis_s1 <= user_test_disable_i;
    dis_s2 <= dis_s1;
    pin_s1 <= pad_in_i;
    pin_s2 <= pin_s1;
    cout_s1 <= core_out_i;
    cout_s2 <= cout_s1;
    coe_s1 <= core_oe_i;
    coe_s2 <= coe_s1;
  end

  assign tap_rst = rst_s2 | (cfg_s2 & ~dis_s2);
  assign tms_eff = tms_driven_i ? tms_i : 1'b1;
  assign tdi_eff = tdi_driven_i ? tdi_i : 1'b1;

  bstp_tap_fsm u_tap (
    .tck_i(tck_i),
    .rst_i(tap_rst),
    .tms_i(tms_eff),
    .state_o(tap_state)
  );

  assign extest = (ir == `BSTP_OP_EXTEST);
  assign bsr_sel = extest | (ir == `BSTP_OP_SAMPLE);

  always_comb begin
    next_ir_sh = ir_sh;
    next_ir = ir;
    next_byp = byp;
    next_bsr_sh = bsr_sh;
    next_bsr_upd = bsr_upd;
    next_upd_tgl = upd_tgl;
    case (tap_state)
      bstp_pkg::TAP_RESET: begin
        next_ir = `BSTP_OP_BYPASS;
      end
      bstp_pkg::TAP_CAP_IR: begin
        next_ir_sh = `BSTP_IR_CAPTURE;
      end
      bstp_pkg::TAP_SHIFT_IR: begin
        next_ir_sh = {tdi_eff, ir_sh[`BSTP_IR_LEN-1:1]};
      end
      bstp_pkg::TAP_UPD_IR: begin
        next_ir = ir_sh;
      end
      bstp_pkg::TAP_CAP_DR: begin
        if (bsr_sel) begin
          for (int i = 0; i < NUM_PINS; i++) begin
            next_bsr_sh[cell_idx(i, `BSTP_CELL_IN)] = pin_s2[i];
            // Output cells record what the pad is really being driven with
            next_bsr_sh[cell_idx(i, `BSTP_CELL_OUT)] = extest ? bsr_upd[cell_idx(i, `BSTP_CELL_OUT)] : cout_s2[i];
            next_bsr_sh[cell_idx(i, `BSTP_CELL_OE)] = extest ? bsr_upd[cell_idx(i, `BSTP_CELL_OE)] : coe_s2[i];
          end
        end else begin
          next_byp = 1'b0;
        end
      end
      bstp_pkg::TAP_SHIFT_DR: begin
        if (bsr_sel) begin
          next_bsr_sh = {tdi_eff, bsr_sh[BSR_LEN-1:1]};
        end else begin
          next_byp = tdi_eff;
        end
      end
      bstp_pkg::TAP_UPD_DR: begin
        if (bsr_sel) begin
          next_bsr_upd = bsr_sh;
          next_upd_tgl = ~upd_tgl;
        end
      end
      default: begin
        next_ir = ir;
      end
    endcase
    // Taken from the next instruction so it settles on the update edge, while TCK may then stand still
    next_ext_tck = (next_ir == `BSTP_OP_EXTEST);
  end

  always_ff @(posedge tck_i) begin
    if (tap_rst) begin
      ir_sh <= `BSTP_IR_CAPTURE;
      ir <= `BSTP_OP_BYPASS;
      byp <= 1'b0;
      bsr_sh <= '0;
      bsr_upd <= '0;
      upd_tgl <= 1'b0;
      ext_tck <= 1'b0;
    end else begin
      ir_sh <= next_ir_sh;
      ir <= next_ir;
      byp <= next_byp;
      bsr_sh <= next_bsr_sh;
      bsr_upd <= next_bsr_upd;
      upd_tgl <= next_upd_tgl;
      ext_tck <= next_ext_tck;
    end
  end

  // TDO launched half a TCK after the shift edge so the next device sees stable data
  always_comb begin
    next_tdo = 1'b1;
    next_tdo_oe_n = 1'b1;
    if (tap_state == bstp_pkg::TAP_SHIFT_IR) begin
      next_tdo = ir_sh[0];
      next_tdo_oe_n = 1'b0;
    end else if (tap_state == bstp_pkg::TAP_SHIFT_DR) begin
      next_tdo = bsr_sel ? bsr_sh[0] : byp;
      next_tdo_oe_n = 1'b0;
    end
  end

  always_ff @(negedge tck_i) begin
    if (tap_rst) begin
      tdo_o <= 1'b1;
      tdo_oe_n_o <= 1'b1;
    end else begin
      tdo_o <= next_tdo;
      tdo_oe_n_o <= next_tdo_oe_n;
    end
  end

  // System clock domain
  logic ext_s1, ext_s2, tgl_s1, tgl_s2, tgl_s3;
  logic [BSR_LEN-1:0] upd_sys, next_upd_sys;
  logic [NUM_PINS-1:0] next_pad_out, next_pad_oe_n;

  // Update word is held for many TCK periods, so the toggle edge marks it stable
  always_comb begin
    next_upd_sys = upd_sys;
    if (tgl_s2 != tgl_s3) begin
      next_upd_sys = bsr_upd;
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      if (ext_s2) begin
        next_pad_out[i] = upd_sys[cell_idx(i, `BSTP_CELL_OUT)];
        next_pad_oe_n[i] = ~upd_sys[cell_idx(i, `BSTP_CELL_OE)];
      end else begin
        next_pad_out[i] = core_out_i[i];
        next_pad_oe_n[i] = ~core_oe_i[i];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      upd_sys <= '0;
      pad_out_o <= '0;
      pad_oe_n_o <= '1;
    end else begin
      // Registered source, so a decode glitch never reaches the synchroniser
      ext_s1 <= ext_tck;
      ext_s2 <= ext_s1;
      tgl_s1 <= upd_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      upd_sys <= next_upd_sys;
      pad_out_o <= next_pad_out;
      pad_oe_n_o <= next_pad_oe_n;
    end
  end

endmodule : bstp_top

// file: tb/bstp_tester.sv
// Board tester model for the test port link
`timescale 1ns/1ps
module bstp_tester (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic drv_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_n_i
);
  logic drv = 1'b1;
  logic seen = 1'b0;
  assign drv_o = drv;
  initial {tck_o, tms_o, tdi_o} = 3'h0;
  // TCK stands still between steps; a released line toggles so it never looks driven
  task step(input logic s, input logic i, output logic o);
    tms_o = drv ? s : ~tms_o;
    tdi_o = drv ? i : ~tdi_o;
    #12 o = tdo_i;
    seen |= ~tdo_oe_n_i;
    tck_o = 1'b1;
    #24 tck_o = 1'b0;
    #12;
  endtask : step
  // Idle to Idle through one scan, bit 0 first
  task scan(input logic ir, input int n, input logic [699:0] di, output logic [699:0] dq);
    logic x;
    step(1'b1, 1'b0, x);
    if (ir) step(1'b1, 1'b0, x);
    step(1'b0, 1'b0, x);
    step(1'b0, 1'b0, x);
    for (int k = 0; k < n; k++) step(k == n - 1, di[k], dq[k]);
    step(1'b1, ~di[n-1], x);
    step(1'b0, di[n-1], x);
  endtask : scan
endmodule : bstp_tester

// file: tb/bstp_top_props.sv
// Pin checker for the boundary-scan test port
`timescale 1ns/1ps
module bstp_top_props #(
  parameter int BSR_LEN = 522,
  parameter int NUM_PINS = BSR_LEN / 3
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tms_driven_i,
  input wire logic cfg_busy_i,
  input wire logic user_test_disable_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_n_o,
  input wire logic [NUM_PINS-1:0] core_oe_i,
  input wire logic [NUM_PINS-1:0] pad_out_o,
  input wire logic [NUM_PINS-1:0] pad_oe_n_o
);
  // Released TMS reads high through the pull-up
  wire logic hi = tms_i | ~tms_driven_i;
  sequence s_five_hi;
    hi [*5];
  endsequence
  sequence s_busy;
    (cfg_busy_i && !user_test_disable_i) [*5];
  endsequence
  a_tdo_off_high: assert property (@(negedge tck_i) disable iff (sys_rst_i) tdo_oe_n_o |-> tdo_o)
    else $error("tdo off but low");
  a_five_tms_reset: assert property (@(posedge tck_i) disable iff (sys_rst_i) s_five_hi |=> tdo_oe_n_o)
    else $error("no reset after tms high");
  a_shift_exit: assert property (@(posedge tck_i) disable iff (sys_rst_i) !tdo_oe_n_o && hi |=> tdo_oe_n_o)
    else $error("tdo on past shift");
  a_shift_stay: assert property (@(posedge tck_i) disable iff (sys_rst_i)
    (!cfg_busy_i [*4]) ##0 (!tdo_oe_n_o && !hi) |=> !tdo_oe_n_o)
    else $error("shift left early");
  a_shift_enter: assert property (@(posedge tck_i) disable iff (sys_rst_i) $fell(tdo_oe_n_o) |-> !$past(hi))
    else $error("shift entered with tms high");
  a_cfg_quiet: assert property (@(posedge tck_i) disable iff (sys_rst_i) s_busy |-> tdo_oe_n_o)
    else $error("tdo on while configuring");
  a_pads_reset: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> &pad_oe_n_o && pad_out_o == '0)
    else $error("pads driven in reset");
  a_pads_follow: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |=> pad_oe_n_o == ~$past(core_oe_i))
    else $error("pads ignore core");
endmodule : bstp_top_props
bind bstp_top bstp_top_props #(.BSR_LEN(BSR_LEN), .NUM_PINS(NUM_PINS)) u_props (.*);

// file: tb/bstp_top_tb.sv
// Bench for the boundary-scan test port
`timescale 1ns/1ps
`include "bstp_regs.svh"
module bstp_top_tb;
  localparam int L = `BSTP_BSR_LEN_SMALL;
  localparam int P = L / `BSTP_CELLS_PER_PIN;
  logic clock_i, sys_rst_i, busy, utd, tck, tms, tdi, drv, tdo, oe_n, t;
  logic [P-1:0] c_out, c_oe, p_in, p_out, p_oe_n, ev;
  logic [699:0] d, pat, cap;
  logic [2:0] codes [6];
  int err_total = 0;
  int comparisons = 0;
  bstp_tester tst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .drv_o(drv), .tdo_i(tdo), .tdo_oe_n_i(oe_n));
  bstp_top #(.BSR_LEN(L)) DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms),
    .tms_driven_i(drv), .tdi_i(tdi), .tdi_driven_i(drv), .tdo_o(tdo), .tdo_oe_n_o(oe_n), .cfg_busy_i(busy),
    .user_test_disable_i(utd), .core_out_i(c_out), .core_oe_i(c_oe), .pad_in_i(p_in), .pad_out_o(p_out),
    .pad_oe_n_o(p_oe_n));
  task chk(input logic [699:0] g, input logic [699:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task complete_run();
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Unused codes must behave as bypass
  task t_bypass();
    codes = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, `BSTP_OP_BYPASS};
    foreach (codes[k]) begin
      tst.scan(1'b1, 3, codes[k], d);
      chk(d[2:0], `BSTP_IR_CAPTURE);
      tst.scan(1'b0, 8, 8'hA5, d);
      chk(d[7:0], 8'h4A);
    end
  endtask : t_bypass
  task t_extest();
    pat = '0;
    for (int i = 0; i < P; i++) begin
      pat[3*i+1] = i[0];
      pat[3*i+2] = 1'b1;
      ev[i] = i[0];
      cap[3*i] = p_in[i];
      cap[3*i+1] = c_out[i];
      cap[3*i+2] = c_oe[i];
    end
    tst.scan(1'b1, 3, `BSTP_OP_SAMPLE, d);
    tst.scan(1'b0, L, pat, d);
    chk(d[L-1:0], cap[L-1:0]);
    repeat (10) @(negedge clock_i);
    chk({p_oe_n, p_out}, {~c_oe, c_out});
    tst.scan(1'b1, 3, `BSTP_OP_EXTEST, d);
    repeat (10) @(negedge clock_i);
    chk({p_oe_n, p_out}, {{P{1'b0}}, ev});
    for (int i = 0; i < P; i++) pat[3*i] = p_in[i];
    pat[L+7:L] = pat[7:0];
    tst.scan(1'b0, L + 8, pat, d);
    chk(d[L+7:0], pat[L+7:0]);
    tst.scan(1'b1, 3, `BSTP_OP_BYPASS, d);
    repeat (10) @(negedge clock_i);
    chk({p_oe_n, p_out}, {~c_oe, c_out});
  endtask : t_extest
  task t_cfg();
    @(negedge clock_i) busy = 1'b1;
    repeat (4) tst.step(1'b1, 1'b0, t);
    tst.seen = 1'b0;
    tst.scan(1'b1, 3, `BSTP_OP_EXTEST, d);
    chk({tst.seen, p_oe_n, p_out}, {1'b0, ~c_oe, c_out});
    @(negedge clock_i) utd = 1'b1;
    repeat (4) tst.step(1'b1, 1'b0, t);
    tst.step(1'b0, 1'b0, t);
    tst.scan(1'b1, 3, `BSTP_OP_SAMPLE, d);
    chk(d[2:0], `BSTP_IR_CAPTURE);
    @(negedge clock_i) {busy, utd} = 2'b00;
  endtask : t_cfg
  // Released TMS must walk the controller from Shift-DR back to reset, dropping the sample instruction
  task t_pull();
    tst.step(1'b1, 1'b0, t);
    tst.step(1'b0, 1'b0, t);
    tst.step(1'b0, 1'b0, t);
    tst.drv = 1'b0;
    repeat (5) tst.step(1'b0, 1'b0, t);
    tst.drv = 1'b1;
    tst.step(1'b0, 1'b0, t);
    tst.scan(1'b0, 8, 8'hA5, d);
    chk(d[7:0], 8'h4A);
  endtask : t_pull
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  initial begin
    {sys_rst_i, busy, utd} = 3'h4;
    c_out = {29{6'h2D}};
    c_oe = {87{2'b01}};
    p_in = {87{2'b10}};
    fork
      repeat (16) @(negedge clock_i);
      repeat (4) tst.step(1'b1, 1'b0, t);
    join
    @(negedge clock_i) sys_rst_i = 1'b0;
    repeat (5) tst.step(1'b1, 1'b0, t);
    tst.step(1'b0, 1'b0, t);
    t_bypass();
    t_extest();
    t_cfg();
    t_pull();
    complete_run();
  end
endmodule : bstp_top_tb
